// >>> core/gafp_alert_protect.sv
// alert latching, gate driver decode and command handling over AXI4-Lite
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Contract
// - direction reversal sets sticky direction flag until explicitly cleared
// - direction flag clears on clear bit, soft sleep or reset
// - with direction alert enabled, flag setting raises the alert
// - command 0x00 disables threshold alert, loads threshold bytes 0 and 1
// - command 0x01 loads threshold bytes 2 and 3, re-enables alert
// - command 0x04 stores both data bytes into settings word, except bit 4, which gives a one-cycle clear and reads back 0
// - charge comparator means charge overcurrent, discharge comparator discharge
// - overcurrent raises alert and sets matching latch until cleared
// - overcurrent alerts whatever the gate force bits say
// - gate output decoded from force bits, latch and comparator
// - free running gate turns transistor off while overcurrent present
// - free running alert latches at first event until cleared
// - gates held released while power-on timeout runs
// - overcurrent alerts in every setting except soft sleep; threshold and direction only when enabled
// - alert holds until clear bit, alert response read, soft sleep or reset
// - alert response read while alerting answers acknowledged byte 0x8F
// - alert pin is open drain, active low
// - counter equal to threshold sets hit flag and raises alert
// - threshold check only when enabled; reset disables it
// - soft sleep clears all pending alerts and latched status
module gafp_alert_protect #(
   parameter int POR_CYCLES = gafp_pkg::POR_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // axi4-lite write
   input wire logic [gafp_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [gafp_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // analog front end
   input wire logic chargeDir,
   input wire logic chgComparatorOut,
   input wire logic disComparatorOut,
   input wire logic [31:0] countValue,
   // open-drain pins
   output logic alertOut,
   output logic alertOe,
   output logic chgGateDrive,
   output logic chgGateOe,
   output logic disGateDrive,
   output logic disGateOe
);
   import gafp_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   gafp_config_type cfg;
   gafp_status_type stat;
   gafp_cmd_type cmd;
   logic [31:0] threshold;
   logic thresholdAlert;
   logic clrPulse;
   logic dirPrev;
   logic porBusy;
   logic [POR_CNT_W-1:0] porCount;
   logic [ADDR_W-1:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic writeGo;
   logic cmdGo;
   logic readTake;
   logic araClear;
   logic dirEvent;
   logic cmpEvent;
   logic alertEvent;
   logic dirFlag;
   logic hitFlag;
   logic chgLatch;
   logic disLatch;
   logic alertPending;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   // ************************************************************
   // power-on timeout
   // ************************************************************
   // timeout after reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         porCount <= '0;
         porBusy <= 1'b1;
      end else if (porBusy) begin
         porCount <= porCount + POR_CNT_W'(1);
         porBusy <= (porCount != POR_CNT_W'(POR_CYCLES - 1));
      end
   end

   // ************************************************************
   // write channel
   // ************************************************************
   // address and data may arrive in either order; readies drop until
   // the response is taken, so one write at a time
   assign writeGo = !awready && !wready && !bvalid;
   assign cmdGo = writeGo && (awAddrHeld == OFF_CMD) &&
                  ((wStrbHeld & CMD_STRB) == CMD_STRB);
   assign cmd = wDataHeld[23:0];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         awAddrHeld <= '0;
         wDataHeld <= '0;
         wStrbHeld <= '0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            awAddrHeld <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (writeGo) begin
            bvalid <= 1'b1;
            bresp <= cmdGo ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // command execution
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         threshold <= THRESHOLD_RESET;
         thresholdAlert <= 1'b1;
      end else if (cmdGo) begin
         if (cmd.code == CMD_THRESH_LOW) begin
            threshold[15:0] <= cmd.data;
            thresholdAlert <= 1'b0;
         end
         if (cmd.code == CMD_THRESH_HIGH) begin
            threshold[31:16] <= cmd.data;
            thresholdAlert <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg <= CONFIG_RESET;
         clrPulse <= 1'b0;
      end else begin
         clrPulse <= 1'b0;
         if (cmdGo && cmd.code == CMD_SETTINGS) begin
            cfg <= cmd.data;
            cfg.clearAlertsBit <= 1'b0;
            clrPulse <= cmd.data[4];
         end
      end
   end

   // ************************************************************
   // events and sticky flags
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dirPrev <= 1'b0;
      end else begin
         dirPrev <= chargeDir;
      end
   end

   assign dirEvent = (chargeDir != dirPrev) && !porBusy;
   assign cmpEvent = cfg.thresholdCheckEnable && thresholdAlert &&
                     (countValue == threshold);
   assign alertEvent = chgComparatorOut || disComparatorOut || cmpEvent ||
                       (dirEvent && cfg.directionAlertEnable);
   // alert response read clears the alert
   assign readTake = arvalid && arready;
   assign araClear = readTake && (araddr == OFF_ALERT_RESP) && alertPending;

   gafp_sticky_flag u_dirFlag (
      .core_clk(core_clk),
      .srst(srst),
      .setEvent(dirEvent),
      .clearPulse(clrPulse),
      .clearLevel(cfg.softSleepBit),
      .flag(dirFlag)
   );

   gafp_sticky_flag u_hitFlag (
      .core_clk(core_clk),
      .srst(srst),
      .setEvent(cmpEvent),
      .clearPulse(clrPulse),
      .clearLevel(cfg.softSleepBit),
      .flag(hitFlag)
   );

   gafp_sticky_flag u_chgLatch (
      .core_clk(core_clk),
      .srst(srst),
      .setEvent(chgComparatorOut),
      .clearPulse(clrPulse),
      .clearLevel(cfg.softSleepBit),
      .flag(chgLatch)
   );

   gafp_sticky_flag u_disLatch (
      .core_clk(core_clk),
      .srst(srst),
      .setEvent(disComparatorOut),
      .clearPulse(clrPulse),
      .clearLevel(cfg.softSleepBit),
      .flag(disLatch)
   );

   // alert held until clear or response
   gafp_sticky_flag u_alert (
      .core_clk(core_clk),
      .srst(srst),
      .setEvent(alertEvent),
      .clearPulse(clrPulse || araClear),
      .clearLevel(cfg.softSleepBit),
      .flag(alertPending)
   );

   // ************************************************************
   // pins
   // ************************************************************
   // oe high means pulling low; released means the transistor is off
   function automatic logic gateOe(input logic hi, input logic lo,
                                   input logic latch, input logic cmp);
      logic oe;
      oe = 1'b0;
      unique case ({hi, lo})
         2'b00: oe = !latch;
         2'b01: oe = 1'b1;
         2'b10: oe = 1'b0;
         2'b11: oe = !cmp;
      endcase
      return oe;
   endfunction

   always_ff @(posedge core_clk) begin
      if (srst) begin
         chgGateOe <= 1'b0;
         disGateOe <= 1'b0;
      end else if (porBusy) begin
         chgGateOe <= 1'b0;
         disGateOe <= 1'b0;
      end else begin
         chgGateOe <= gateOe(cfg.chgGateForceHigh, cfg.chgGateForceLow,
                             chgLatch, chgComparatorOut);
         disGateOe <= gateOe(cfg.disGateForceHigh, cfg.disGateForceLow,
                             disLatch, disComparatorOut);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         alertOe <= 1'b0;
         alertOut <= 1'b0;
         chgGateDrive <= 1'b0;
         disGateDrive <= 1'b0;
      end else begin
         alertOe <= alertPending;
         alertOut <= 1'b0;
         chgGateDrive <= 1'b0;
         disGateDrive <= 1'b0;
      end
   end

   // ************************************************************
   // read channel
   // ************************************************************
   assign stat = '{porBusy: porBusy, chargeDir: chargeDir,
                   thresholdAlert: thresholdAlert,
                   alertPending: alertPending,
                   disOvercurrentLatch: disLatch,
                   chgOvercurrentLatch: chgLatch,
                   thresholdHitFlag: hitFlag,
                   directionFlippedFlag: dirFlag};

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      unique case (araddr)
         OFF_CMD: next_rdata = 32'h0000_0000;
         OFF_CONFIG: next_rdata = {16'h0000, cfg};
         OFF_STATUS: next_rdata = {16'h0000, STATUS_UNUSED_ONES, stat};
         OFF_THRESHOLD: next_rdata = threshold;
         // bit 8 marks the acknowledge
         OFF_ALERT_RESP: next_rdata = alertPending ?
                            {23'h00_0000, 1'b1, ALERT_RESP_BYTE} :
                            32'h0000_0000;
         default: next_rresp = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         if (readTake) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_settingsWrite;
      cmdGo && cmd.code == CMD_SETTINGS;
   endsequence

   sequence s_sleepHeld;
      cfg.softSleepBit [*2];
   endsequence

   property p_dirSticky;
      dirEvent && !cfg.softSleepBit |=> dirFlag;
   endproperty
   a_dirSticky: assert property (p_dirSticky)
      else $error("direction change not latched");

   property p_dirClear;
      s_settingsWrite ##0 cmd.data[4] ##1 !dirEvent |=> !dirFlag;
   endproperty
   a_dirClear: assert property (p_dirClear)
      else $error("direction flag survived clear");

   property p_dirAlert;
      dirEvent && cfg.directionAlertEnable && !cfg.softSleepBit
         |=> alertPending ##1 alertOe;
   endproperty
   a_dirAlert: assert property (p_dirAlert)
      else $error("direction alert missing");

   property p_cmdLow;
      cmdGo && cmd.code == CMD_THRESH_LOW
         |=> !thresholdAlert && threshold[15:0] == $past(cmd.data);
   endproperty
   a_cmdLow: assert property (p_cmdLow)
      else $error("low threshold command wrong");

   property p_cmdHigh;
      cmdGo && cmd.code == CMD_THRESH_HIGH
         |=> thresholdAlert && threshold[31:16] == $past(cmd.data);
   endproperty
   a_cmdHigh: assert property (p_cmdHigh)
      else $error("high threshold command wrong");

   property p_settings;
      s_settingsWrite |=> cfg[15:5] == $past(cmd.data[15:5]) &&
         cfg[3:0] == $past(cmd.data[3:0]) && !cfg.clearAlertsBit;
   endproperty
   a_settings: assert property (p_settings)
      else $error("settings word not stored");

   property p_ocLatch;
      chgComparatorOut && !cfg.softSleepBit |=> chgLatch && alertPending;
   endproperty
   a_ocLatch: assert property (p_ocLatch)
      else $error("overcurrent not latched");

   property p_freeRun;
      !porBusy && cfg.disGateForceHigh && cfg.disGateForceLow
         |=> disGateOe == !$past(disComparatorOut);
   endproperty
   a_freeRun: assert property (p_freeRun)
      else $error("free running gate wrong");

   property p_porRelease;
      porBusy |=> !chgGateOe && !disGateOe;
   endproperty
   a_porRelease: assert property (p_porRelease)
      else $error("gate driven during power-on timeout");

   property p_alertResp;
      araClear |=> rvalid && rdata[8:0] == {1'b1, ALERT_RESP_BYTE}
         ##0 !alertPending || $past(alertEvent);
   endproperty
   a_alertResp: assert property (p_alertResp)
      else $error("alert response wrong");

   property p_sleepClear;
      s_sleepHeld |-> !alertPending && !chgLatch && !dirFlag;
   endproperty
   a_sleepClear: assert property (p_sleepClear)
      else $error("soft sleep left status set");

   property p_clrOnce;
      clrPulse |=> !clrPulse && !cfg.clearAlertsBit;
   endproperty
   a_clrOnce: assert property (p_clrOnce)
      else $error("clear bit stayed set");

endmodule

// >>> core/gafp_pkg.sv
// shared constants and types of the gauge alert and gate protection block
package gafp_pkg;

   // ************************************************************
   // register map on the control bus
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_THRESHOLD = 8'h0C;
   localparam logic [7:0] OFF_ALERT_RESP = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] CMD_STRB = 4'h7;

   // ************************************************************
   // command codes and alert response
   // ************************************************************
   localparam logic [7:0] CMD_THRESH_LOW = 8'h00;
   localparam logic [7:0] CMD_THRESH_HIGH = 8'h01;
   localparam logic [7:0] CMD_SETTINGS = 8'h04;
   // seven-bit bus address answered by the alert response register
   localparam logic [6:0] ALERT_RESP_BUS_ADDR = 7'h0C;
   localparam logic [7:0] ALERT_RESP_BYTE = 8'h8F;
   localparam logic [7:0] STATUS_UNUSED_ONES = 8'hFF;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0000;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ = 100;
   localparam int POR_TIMEOUT_US = 25000;
   localparam int POR_CYCLES = POR_TIMEOUT_US * CLK_MHZ;
   localparam int POR_CNT_W = 22;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] spare;
      logic softSleepBit;
      logic thresholdCheckEnable;
      logic directionAlertEnable;
      logic clearAlertsBit;
      logic disGateForceHigh;
      logic disGateForceLow;
      logic chgGateForceHigh;
      logic chgGateForceLow;
   } gafp_config_type;

   typedef struct packed {
      logic porBusy;
      logic chargeDir;
      logic thresholdAlert;
      logic alertPending;
      logic disOvercurrentLatch;
      logic chgOvercurrentLatch;
      logic thresholdHitFlag;
      logic directionFlippedFlag;
   } gafp_status_type;

   typedef struct packed {
      logic [7:0] code;
      logic [15:0] data;
   } gafp_cmd_type;

endpackage

// >>> core/gafp_sticky_flag.sv
// sticky event flag with pulse clear and level clear
`timescale 1ns/1ns
module gafp_sticky_flag (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // control
   input wire logic setEvent,
   input wire logic clearPulse,
   input wire logic clearLevel,
   // state
   output logic flag
);

   // set beats a pulse clear; a level clear (sleep) beats everything
   always_ff @(posedge core_clk) begin
      if (srst || clearLevel) begin
         flag <= 1'b0;
      end else if (setEvent) begin
         flag <= 1'b1;
      end else if (clearPulse) begin
         flag <= 1'b0;
      end
   end

endmodule

// >>> sim/gafp_host_model.sv
// bus master model standing in for the host controller
`timescale 1ns/1ns
module gafp_host_model (
   // clock
   input wire logic core_clk,
   // write channels
   output logic [gafp_pkg::ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic [gafp_pkg::ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   // alert wire as seen on the board
   input wire logic alertLineN
);
   import gafp_pkg::*;
   // bound on every wait; the bench treats a miss as a hang
   localparam int WAIT_MAX = 64;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // ************************************************************
   // bus cycles, entered just after a rising edge
   // ************************************************************
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] resp, output logic ok);
      ok = 1'b0;
      resp = RESP_SLVERR;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < WAIT_MAX && !ok; n++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            ok = 1'b1;
            resp = bresp;
            bready <= 1'b0;
         end
      end
      // one idle edge so the next request never re-raises bready now
      @(posedge core_clk);
   endtask
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] resp, output logic ok);
      ok = 1'b0;
      d = '0;
      resp = RESP_SLVERR;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < WAIT_MAX && !ok; n++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            ok = 1'b1;
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
         end
      end
      // one idle edge so the next request never re-raises rready now
      @(posedge core_clk);
   endtask
   task automatic set_settings(input logic [15:0] v, input logic allowLow,
      output logic ok);
      logic [1:0] resp;
      bus_write(OFF_CMD, {8'h00, CMD_SETTINGS, allowLow ? v : v & 16'hFFFA},
         CMD_STRB, resp, ok);
      ok = ok && resp === RESP_OKAY;
   endtask
   // identify who pulled the alert wire
   task automatic alert_ack(output logic [31:0] d, output logic ok);
      logic [1:0] resp;
      d = '0;
      ok = 1'b0;
      if (alertLineN === 1'b0) begin
         bus_read(OFF_ALERT_RESP, d, resp, ok);
         ok = ok && resp === RESP_OKAY;
      end
   endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the alert and gate protection block
`timescale 1ns/1ns
module tb;
   import gafp_pkg::*;
   // short power-on timeout keeps the run brief
   localparam int POR = 20;
   logic core_clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, chargeDir, chgComparatorOut;
   logic disComparatorOut, alertOut, alertOe, chgGateDrive, chgGateOe;
   logic disGateDrive, disGateOe, alertLineN, ok;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, countValue, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int badCount = 0;
   int cmpCount = 0;
   // pull-up on the alert wire
   assign alertLineN = alertOe ? alertOut : 1'b1;
   gafp_alert_protect #(.POR_CYCLES(POR)) i_dut (.core_clk(core_clk),
      .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .chargeDir(chargeDir),
      .chgComparatorOut(chgComparatorOut), .countValue(countValue),
      .disComparatorOut(disComparatorOut), .alertOut(alertOut),
      .alertOe(alertOe), .chgGateDrive(chgGateDrive), .chgGateOe(chgGateOe),
      .disGateDrive(disGateDrive), .disGateOe(disGateOe));
   gafp_host_model i_host (.core_clk(core_clk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .alertLineN(alertLineN));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic testDone;
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chkw({31'd0, got}, {31'd0, exp});
   endtask
   task automatic need(input logic okay);
      if (okay !== 1'b1) begin
         chkb(okay, 1'b1);
         testDone();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr_cmd(input logic [7:0] code, input logic [15:0] v);
      i_host.bus_write(OFF_CMD, {8'h00, code, v}, CMD_STRB, resp, ok);
      need(ok && resp === RESP_OKAY);
   endtask
   task automatic cfg(input logic [15:0] v, input logic allowLow);
      i_host.set_settings(v, allowLow, ok);
      need(ok);
      tick(3);
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.bus_read(a, d, resp, ok);
      need(ok && resp === RESP_OKAY);
   endtask
   task automatic pulse(input logic chg);
      if (chg) chgComparatorOut <= 1'b1;
      else disComparatorOut <= 1'b1;
      tick(1);
      chgComparatorOut <= 1'b0;
      disComparatorOut <= 1'b0;
      tick(3);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_por;
      tick(3);
      chkb(chgGateOe | disGateOe, 1'b0);
      rd(OFF_STATUS);
      chkw(d & 32'hFFFF_FF80, 32'h0000_FF80);
      tick(POR + 4);
      chkw(32'({alertLineN, chgGateOe, disGateOe, alertOut, chgGateDrive,
         disGateDrive}), 32'h38);
      $display("power-on test done");
   endtask
   task automatic t_cmd;
      wr_cmd(CMD_THRESH_LOW, 16'h1234);
      rd(OFF_THRESHOLD);
      chkw(d, 32'h0000_1234);
      rd(OFF_STATUS);
      chkb(d[5], 1'b0);
      wr_cmd(CMD_THRESH_HIGH, 16'hABCD);
      rd(OFF_THRESHOLD);
      chkw(d, 32'hABCD_1234);
      rd(OFF_STATUS);
      chkw(32'(d[5:1]), 32'h10);
      countValue <= 32'hABCD_1234;
      cfg(16'h0040, 1'b0);
      rd(OFF_CONFIG);
      chkw(d, 32'h0000_0040);
      rd(OFF_STATUS);
      chkw(32'({d[1], alertOe}), 32'h3);
      countValue <= 32'h0000_0000;
      cfg(16'h0010, 1'b0);
      rd(OFF_STATUS);
      chkw(32'({d[1], alertOe}), 32'h0);
      i_host.bus_write(OFF_CMD, {8'h00, CMD_SETTINGS, 16'h00C0}, 4'h3,
         resp, ok);
      need(ok);
      chkw({30'd0, resp}, {30'd0, RESP_SLVERR});
      i_host.bus_read(8'h20, d, resp, ok);
      need(ok);
      chkw({d[29:0], resp}, {30'd0, RESP_SLVERR});
      rd(OFF_CONFIG);
      chkw(d, 32'h0000_0000);
      $display("command test done");
   endtask
   task automatic t_dir;
      chargeDir <= ~chargeDir;
      tick(3);
      rd(OFF_STATUS);
      chkw(32'({d[0], alertOe}), 32'h2);
      chargeDir <= ~chargeDir;
      tick(3);
      rd(OFF_STATUS);
      chkb(d[0], 1'b1);
      cfg(16'h0010, 1'b0);
      rd(OFF_STATUS);
      chkb(d[0], 1'b0);
      cfg(16'h0020, 1'b0);
      chargeDir <= ~chargeDir;
      tick(3);
      chkb(alertLineN, 1'b0);
      tick(4);
      chkb(alertOe, 1'b1);
      i_host.alert_ack(d, ok);
      need(ok);
      chkw(d, {24'd1, ALERT_RESP_BYTE});
      tick(3);
      chkb(alertOe, 1'b0);
      chargeDir <= ~chargeDir;
      tick(3);
      cfg(16'h00A0, 1'b0);
      rd(OFF_STATUS);
      chkw(32'({d[4:0], alertOe}), 32'h0);
      cfg(16'h0000, 1'b0);
      $display("direction test done");
   endtask
   task automatic t_oc;
      pulse(1'b1);
      rd(OFF_STATUS);
      chkw(32'({d[3:2], alertOe, chgGateOe, disGateOe}), 32'hD);
      pulse(1'b0);
      rd(OFF_STATUS);
      chkw(32'({d[3:2], disGateOe}), 32'h6);
      cfg(16'h0010, 1'b0);
      rd(OFF_STATUS);
      chkw(32'({d[3:2], alertOe, chgGateOe, disGateOe}), 32'h3);
      cfg(16'h0005, 1'b1);
      pulse(1'b1);
      chkw(32'({alertOe, chgGateOe, disGateOe}), 32'h7);
      cfg(16'h001F, 1'b1);
      chgComparatorOut <= 1'b1;
      disComparatorOut <= 1'b1;
      tick(3);
      chkw(32'({alertOe, chgGateOe, disGateOe}), 32'h4);
      chgComparatorOut <= 1'b0;
      disComparatorOut <= 1'b0;
      tick(3);
      chkw(32'({alertOe, chgGateOe, disGateOe}), 32'h7);
      cfg(16'h001A, 1'b0);
      chkw(32'({alertOe, chgGateOe, disGateOe}), 32'h0);
      cfg(16'h0010, 1'b0);
      $display("overcurrent test done");
   endtask
   initial begin
      srst = 1'b1;
      chargeDir = 1'b0;
      chgComparatorOut = 1'b0;
      disComparatorOut = 1'b0;
      countValue = 32'h0000_0000;
      tick(5);
      srst <= 1'b0;
      t_por();
      t_cmd();
      t_dir();
      t_oc();
      testDone();
   end
endmodule
